// ==== design/dcp_charge_port_power.sv ====
/*
  downstream charge port power control: charge enable register plus
  per-port power source selection for a small hub.
  assumes a serial configuration engine presents byte writes and reads
  synchronous to i_clock and pulses i_cfg_done once loading ends.
*/
// Functional notes
// - each port independently configurable for charging
// - charging supply indication per port, own config
// - enabled port charging host, else standard port
// - mode never changes after configuration completes
// - answer charge query only yes, never no
// - charging logic drives power on enabled ports
// - power on after configuration until overcurrent/enumeration
// - overcurrent drops power; a tripped charging port re-enables only on reset or PORT_POWER handover to hub logic
// - after enumeration hub logic controls power
// - PORT_POWER one hub, zero charging logic; code keeps hub control after PORT_POWER returns to zero
// - overcurrent always drops port power
// - enable bit one maps port one upward
// - enabled ports assert their power register bit
`timescale 1ns/1ps
`include "dcp_defs.svh"

module dcp_charge_port_power (
  input  wire logic                        i_clock,
  input  wire logic                        i_sys_rst,
  input  wire dcp_pkg::dcp_cfg_req_t       i_cfg_req,
  output logic [`DCP_REG_DATA_W-1:0]       o_cfg_rdata,
  input  wire logic                        i_cfg_done,
  input  wire dcp_pkg::dcp_hub_ctl_t       i_hub_ctl,
  input  wire dcp_pkg::dcp_port_vec_t      i_overcurrent_sense_n,
  input  wire dcp_pkg::dcp_port_vec_t      i_charge_query,
  output dcp_pkg::dcp_port_vec_t           o_charge_ack,
  output dcp_pkg::dcp_port_vec_t           o_port_power_out,
  output dcp_pkg::dcp_port_vec_t           o_charge_supply_present,
  output dcp_pkg::dcp_port_vec_t           o_tripped,
  output logic                             o_cfg_locked
);

  logic [`DCP_REG_DATA_W-1:0] charge_enable_mask_q;
  logic                       cfg_locked_q;
  logic                       supply_valid_q;
  dcp_pkg::dcp_port_vec_t     supply_q;
  dcp_pkg::dcp_port_vec_t     ack_q;
  dcp_pkg::dcp_port_vec_t     charge_mode;

  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  // bit 0 and bits past the last port are dropped here
  function automatic dcp_pkg::dcp_port_vec_t port_bits(input logic [`DCP_REG_DATA_W-1:0] mask);
    port_bits = mask[`DCP_FIRST_PORT_BIT +: `DCP_NUM_PORTS];
  endfunction

  function automatic logic hit(input logic [`DCP_REG_ADDR_W-1:0] addr);
    hit = (addr == `DCP_CHARGE_EN_OFFSET);
  endfunction

  // --------------------------------------------------
  // charge enable register
  // --------------------------------------------------
  // writes only land while the serial load runs; later writes are
  // dropped so a port can never change type once running
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      charge_enable_mask_q <= `DCP_CHARGE_EN_RESET;
    end else if (i_cfg_req.wr_en && hit(i_cfg_req.addr) && !cfg_locked_q) begin
      charge_enable_mask_q <= i_cfg_req.wdata;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_locked_q <= 1'b0;
    end else if (i_cfg_done) begin
      cfg_locked_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cfg_rdata <= '0;
    end else if (hit(i_cfg_req.addr)) begin
      o_cfg_rdata <= charge_enable_mask_q;
    end else begin
      o_cfg_rdata <= '0;
    end
  end

  // --------------------------------------------------
  // per-port supply indication and query answer
  // --------------------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      supply_q <= '0;
    end else if (cfg_locked_q) begin
      supply_q <= port_bits(charge_enable_mask_q);
    end
  end

  // ports are released at the same edge that supply_q loads, so each port
  // takes its type from the stored mask and never from the reset value
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      supply_valid_q <= 1'b0;
    end else begin
      supply_valid_q <= cfg_locked_q;
    end
  end

  // a disabled port stays silent: no negative answer exists
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_q <= '0;
    end else begin
      ack_q <= i_charge_query & supply_q;
    end
  end

  assign o_charge_ack            = ack_q;
  assign o_charge_supply_present = supply_q;
  assign o_cfg_locked            = cfg_locked_q;

  // --------------------------------------------------
  // port power controllers
  // --------------------------------------------------
  for (genvar p = 0; p < `DCP_NUM_PORTS; p++) begin : g_port
    dcp_port_ctrl dcp_port_ctrl_i (
      .i_clock               (i_clock),
      .i_sys_rst             (i_sys_rst),
      .i_cfg_done            (supply_valid_q),
      .i_charge_en           (supply_q[p]),
      .i_power_feature       (i_hub_ctl.power_feature[p]),
      .i_hub_power           (i_hub_ctl.hub_power[p]),
      .i_overcurrent_sense_n (i_overcurrent_sense_n[p]),
      .o_port_power_out      (o_port_power_out[p]),
      .o_charge_mode         (charge_mode[p]),
      .o_tripped             (o_tripped[p])
    );
  end

  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  sequence s_trip(int p);
    !i_overcurrent_sense_n[p];
  endsequence

  sequence s_cfg_end(int p);
    $rose(supply_valid_q) && supply_q[p] && i_overcurrent_sense_n[p] && !i_hub_ctl.power_feature[p];
  endsequence

  sequence s_hub_ctl(int p);
    !charge_mode[p] && !o_tripped[p] && $past(supply_valid_q) && i_overcurrent_sense_n[p]
      && i_hub_ctl.power_feature[p];
  endsequence

  for (genvar a = 0; a < `DCP_NUM_PORTS; a++) begin : g_chk
    AST_OC_DROPS: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      s_trip(a) |=> !o_port_power_out[a])
      else $error("port power stayed on after overcurrent");
    AST_TRIP_HOLDS: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (o_tripped[a] && !i_hub_ctl.power_feature[a]) |=> !o_port_power_out[a] && o_tripped[a])
      else $error("tripped port re-powered without reset");
    AST_CHARGE_ON: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (charge_mode[a] && i_overcurrent_sense_n[a]) |=> o_port_power_out[a])
      else $error("charging port not powered");
    AST_NO_ACK_OFF: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !supply_q[a] |=> !o_charge_ack[a])
      else $error("charge query answered on disabled port");
    AST_ACK_ON: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (i_charge_query[a] && supply_q[a]) |=> o_charge_ack[a])
      else $error("charge query not answered");
    AST_HUB_FOLLOW: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      s_hub_ctl(a) ##1 i_overcurrent_sense_n[a] |-> o_port_power_out[a] == $past(i_hub_ctl.hub_power[a]))
      else $error("hub logic not in control of port power");
    AST_TRIP_ENTER: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (charge_mode[a] && !i_overcurrent_sense_n[a]) |=> o_tripped[a])
      else $error("charging port did not trip on overcurrent");
    AST_TRIP_SOURCE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      o_tripped[a] |-> supply_q[a])
      else $error("port without charging support tripped");
    AST_NO_CHARGE_OFF: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !supply_q[a] |-> !charge_mode[a])
      else $error("standard port under charging control");
    AST_HUB_TAKES: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (charge_mode[a] && i_hub_ctl.power_feature[a] && i_overcurrent_sense_n[a]) |=> (!charge_mode[a] && !o_tripped[a]))
      else $error("port power feature did not hand over to hub logic");
    AST_CHARGE_START: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      s_cfg_end(a) ##1 i_overcurrent_sense_n[a] |=> o_port_power_out[a])
      else $error("charging port not powered after configuration");
    AST_DISABLED_HUB: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      ($past(supply_valid_q) && !supply_q[a] && i_overcurrent_sense_n[a])
      |=> o_port_power_out[a] == $past(i_hub_ctl.hub_power[a]))
      else $error("standard port not following hub logic");
    AST_POWER_PRE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !supply_valid_q |-> !o_port_power_out[a])
      else $error("port powered before configuration");
    AST_QUERY_QUIET: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !i_charge_query[a] |=> !o_charge_ack[a])
      else $error("charge answer without a query");
  end

  AST_MODE_FROZEN: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $past(supply_valid_q) |-> $stable(supply_q))
    else $error("port type changed after configuration");
  AST_READ_BACK: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    hit(i_cfg_req.addr) |=> o_cfg_rdata == $past(charge_enable_mask_q))
    else $error("enable register read back wrong");
  AST_READ_ZERO: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !hit(i_cfg_req.addr) |=> o_cfg_rdata == '0)
    else $error("unmapped address did not read zero");
  AST_LOCK_WRITE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    cfg_locked_q |=> $stable(charge_enable_mask_q))
    else $error("enable register changed after configuration");
  AST_MAP: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    cfg_locked_q |=> supply_q == port_bits($past(charge_enable_mask_q)))
    else $error("enable bit to port mapping wrong");

endmodule

// ==== design/dcp_defs.svh ====
/*
  constants for the downstream charge port power control block.
  assumes inclusion by bare name from design files.
*/
`ifndef DCP_DEFS_SVH
`define DCP_DEFS_SVH

// --------------------------------------------------
// geometry and register map
// --------------------------------------------------
`define DCP_NUM_PORTS        3
`define DCP_REG_ADDR_W       8
`define DCP_REG_DATA_W       8
`define DCP_CHARGE_EN_OFFSET 8'hd0
`define DCP_CHARGE_EN_RESET  8'h00
`define DCP_FIRST_PORT_BIT   1

`endif

// ==== design/dcp_pkg.sv ====
/*
  types shared by the charge port power control block.
  assumes dcp_defs.svh is reachable on the include path.
*/
`include "dcp_defs.svh"

package dcp_pkg;

  typedef logic [`DCP_NUM_PORTS-1:0] dcp_port_vec_t;

  // serial configuration register write/read request
  typedef struct packed {
    logic                         wr_en;
    logic [`DCP_REG_ADDR_W-1:0]   addr;
    logic [`DCP_REG_DATA_W-1:0]   wdata;
  } dcp_cfg_req_t;

  // per-port view into the hub core
  typedef struct packed {
    dcp_port_vec_t hub_power;     // hub logic port power request
    dcp_port_vec_t power_feature; // PORT_POWER feature state per port
  } dcp_hub_ctl_t;

  typedef enum logic [1:0] {
    DCP_ST_WAIT_CFG = 2'b00,
    DCP_ST_CHARGING = 2'b01,
    DCP_ST_TRIPPED  = 2'b11,
    DCP_ST_HUB_CTRL = 2'b10
  } dcp_port_state_t;

endpackage

// ==== design/dcp_port_ctrl.sv ====
/*
  one downstream port: chooses between charging and hub power control.
  assumes overcurrent input is already synchronous to i_clock.
*/
`timescale 1ns/1ps
`include "dcp_defs.svh"

module dcp_port_ctrl (
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  input  wire logic i_cfg_done,
  input  wire logic i_charge_en,
  input  wire logic i_power_feature,
  input  wire logic i_hub_power,
  input  wire logic i_overcurrent_sense_n,
  output logic      o_port_power_out,
  output logic      o_charge_mode,
  output logic      o_tripped
);

  dcp_pkg::dcp_port_state_t state_q;
  logic                     power_q;

  // --------------------------------------------------
  // port control state
  // --------------------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= dcp_pkg::DCP_ST_WAIT_CFG;
    end else begin
      case (state_q)
        dcp_pkg::DCP_ST_WAIT_CFG: begin
          // mode is frozen here; later enable writes never move a port
          if (i_cfg_done) begin
            if (!i_charge_en) begin
              state_q <= dcp_pkg::DCP_ST_HUB_CTRL;
            end else if (!i_overcurrent_sense_n) begin
              state_q <= dcp_pkg::DCP_ST_TRIPPED;
            end else if (i_power_feature) begin
              state_q <= dcp_pkg::DCP_ST_HUB_CTRL;
            end else begin
              state_q <= dcp_pkg::DCP_ST_CHARGING;
            end
          end
        end
        dcp_pkg::DCP_ST_CHARGING: begin
          if (!i_overcurrent_sense_n) begin
            state_q <= dcp_pkg::DCP_ST_TRIPPED;
          end else if (i_power_feature) begin
            state_q <= dcp_pkg::DCP_ST_HUB_CTRL;
          end
        end
        dcp_pkg::DCP_ST_TRIPPED: begin
          // a device reset, or PORT_POWER handing over to hub control, leaves this state
          if (i_power_feature) begin
            state_q <= dcp_pkg::DCP_ST_HUB_CTRL;
          end
        end
        dcp_pkg::DCP_ST_HUB_CTRL: begin
          state_q <= dcp_pkg::DCP_ST_HUB_CTRL;
        end
        default: begin
          state_q <= dcp_pkg::DCP_ST_WAIT_CFG;
        end
      endcase
    end
  end

  // --------------------------------------------------
  // power output
  // --------------------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      power_q <= 1'b0;
    end else if (!i_overcurrent_sense_n) begin
      power_q <= 1'b0;
    end else begin
      case (state_q)
        dcp_pkg::DCP_ST_CHARGING: power_q <= 1'b1;
        dcp_pkg::DCP_ST_HUB_CTRL: power_q <= i_hub_power;
        default:                  power_q <= 1'b0;
      endcase
    end
  end

  assign o_port_power_out = power_q;
  assign o_charge_mode    = (state_q == dcp_pkg::DCP_ST_CHARGING);
  assign o_tripped        = (state_q == dcp_pkg::DCP_ST_TRIPPED);

endmodule

// ==== verif/dcp_query_dev.sv ====
/*
  model of the downstream devices: each asks its port whether charging is
  supported and notes whether a yes came back.
  assumes one query window at a time, started by the bench.
*/
`timescale 1ns/1ps

module dcp_query_dev (
  input  wire logic                   i_clock,
  input  wire logic                   i_sys_rst,
  input  wire dcp_pkg::dcp_port_vec_t i_ask,
  input  wire dcp_pkg::dcp_port_vec_t i_ack,
  output dcp_pkg::dcp_port_vec_t      o_query,
  output dcp_pkg::dcp_port_vec_t      o_acked
);
  logic [2:0] win_q;

  // query held as a level for a short window, then dropped
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      win_q   <= 3'h0;
      o_query <= '0;
    end else if (|i_ask) begin
      win_q   <= 3'h4;
      o_query <= i_ask;
    end else if (win_q != 3'h0) begin
      win_q <= win_q - 3'h1;
    end else begin
      o_query <= '0;
    end
  end

  // silence means no: only a yes inside the window counts
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_acked <= '0;
    end else if (|i_ask) begin
      o_acked <= '0;
    end else begin
      o_acked <= o_acked | (i_ack & o_query);
    end
  end
endmodule

// ==== verif/tb_dcp_charge_port_power.sv ====
/*
  self-checking bench for the charge port power block.
  assumes the design files and package are compiled first.
*/
`timescale 1ns/1ps

module tb_dcp_charge_port_power;
  logic                   clk;
  logic                   rst;
  logic                   done;
  logic                   locked;
  logic [7:0]             rdata;
  dcp_pkg::dcp_cfg_req_t  req;
  dcp_pkg::dcp_hub_ctl_t  hub;
  dcp_pkg::dcp_port_vec_t oc_n, ask, query, ack, acked, pwr, supply, trip;
  int                     n_mismatch, total_checks, cycles;

  dcp_charge_port_power dcp_charge_port_power_i (
    .i_clock(clk), .i_sys_rst(rst), .i_cfg_req(req), .o_cfg_rdata(rdata), .i_cfg_done(done),
    .i_hub_ctl(hub), .i_overcurrent_sense_n(oc_n), .i_charge_query(query), .o_charge_ack(ack),
    .o_port_power_out(pwr), .o_charge_supply_present(supply), .o_tripped(trip), .o_cfg_locked(locked));

  dcp_query_dev dcp_query_dev_i (
    .i_clock(clk), .i_sys_rst(rst), .i_ask(ask), .i_ack(ack), .o_query(query), .o_acked(acked));

  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = {1'b1, a, d};
    cyc(1);
    req.wr_en = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req.addr = a;
    cyc(2);
    chk("rdata", rdata, e);
  endtask

  // configuration ends; power needs a few cycles to come up
  task automatic finish_cfg();
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(6);
  endtask

  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  task automatic t_reset();
    chk("power", 8'(pwr), 8'h00);
    rd(8'hd0, 8'h00);
  endtask

  task automatic t_config();
    wr(8'hd0, 8'h0b);
    wr(8'hd1, 8'hff);
    rd(8'hd0, 8'h0b);
    rd(8'hd1, 8'h00);
    chk("power", 8'(pwr), 8'h00);
    finish_cfg();
    chk("locked", 8'(locked), 8'h01);
    chk("supply", 8'(supply), 8'h05);
    chk("power", 8'(pwr), 8'h05);
    wr(8'hd0, 8'h04);
    rd(8'hd0, 8'h0b);
    hub.hub_power = 3'h2;
    cyc(3);
    chk("power", 8'(pwr), 8'h07);
    hub.hub_power = 3'h0;
    cyc(3);
    chk("power", 8'(pwr), 8'h05);
  endtask

  task automatic t_query();
    ask = 3'h7;
    cyc(1);
    ask = 3'h0;
    cyc(6);
    chk("acked", 8'(acked), 8'h05);
  endtask

  task automatic t_overcurrent();
    oc_n = 3'h6;
    cyc(2);
    chk("power", 8'(pwr), 8'h04);
    chk("tripped", 8'(trip), 8'h01);
    oc_n = 3'h7;
    hub.hub_power = 3'h3;
    cyc(4);
    chk("power", 8'(pwr), 8'h06);
    oc_n = 3'h5;
    cyc(2);
    chk("power", 8'(pwr), 8'h04);
    oc_n = 3'h7;
    cyc(2);
  endtask

  task automatic t_enumerate();
    hub = {3'h0, 3'h7};
    cyc(3);
    chk("power", 8'(pwr), 8'h00);
    hub.hub_power = 3'h5;
    cyc(3);
    chk("power", 8'(pwr), 8'h05);
    chk("supply", 8'(supply), 8'h05);
    oc_n = 3'h3;
    cyc(2);
    chk("power", 8'(pwr), 8'h01);
    oc_n = 3'h7;
  endtask

  // only a reset brings a tripped port back under charging control
  task automatic t_rereset();
    rst = 1'b1;
    cyc(2);
    chk("power", 8'(pwr), 8'h00);
    rst = 1'b0;
    hub = '0;
    cyc(1);
    wr(8'hd0, 8'hf2);
    finish_cfg();
    chk("power", 8'(pwr), 8'h01);
    chk("supply", 8'(supply), 8'h01);
    chk("tripped", 8'(trip), 8'h00);
  endtask

  initial begin
    rst  = 1'b1;
    done = 1'b0;
    req  = '0;
    hub  = '0;
    oc_n = 3'h7;
    ask  = 3'h0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    cyc(1);
    t_reset();
    t_config();
    t_query();
    t_overcurrent();
    t_enumerate();
    t_rereset();
    conclude();
  end
endmodule
